/* hw/usr_pkg.sv */
package usr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes

   localparam int USR_WIDTH = 8;
   localparam int USR_FIFO_DEPTH = 16;
   localparam int USR_SYNC_STAGES = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values

   localparam logic [USR_WIDTH-1:0] USR_STAGE_RST = 8'h00;
   localparam logic USR_OE_N_RST = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // Mode select encodings, index {mode_sel_hi, mode_sel_lo}

   localparam logic [1:0] USR_SEL_HOLD = 2'h0;
   localparam logic [1:0] USR_SEL_RIGHT = 2'h1;
   localparam logic [1:0] USR_SEL_LEFT = 2'h2;
   localparam logic [1:0] USR_SEL_LOAD = 2'h3;

   typedef enum logic [1:0] {
      USR_MODE_HOLD,
      USR_MODE_RIGHT,
      USR_MODE_LEFT,
      USR_MODE_LOAD
   } usr_mode_t;

   ////////////////////////////////////////////////////////////////////////////
   // Carriers

   // Pin bundle as seen after the synchroniser
   typedef struct packed {
      logic shift_clock;
      logic mode_sel_hi;
      logic mode_sel_lo;
      logic ser_in_right;
      logic ser_in_left;
      logic out_en_n_a;
      logic out_en_n_b;
      logic master_clear_n;
      logic [USR_WIDTH-1:0] par_in;
   } usr_pins_t;

   localparam int USR_PINS_W = $bits(usr_pins_t);

   // Clock low, enables off, clear asserted until the pins are seen
   localparam logic [USR_PINS_W-1:0] USR_PINS_RST = 16'h0600;

   // One queued clock-edge operation
   typedef struct packed {
      usr_mode_t mode;
      logic ser_in_right;
      logic ser_in_left;
      logic [USR_WIDTH-1:0] par_in;
   } usr_cmd_t;

   localparam int USR_CMD_W = $bits(usr_cmd_t);

endpackage

/* hw/usr_sync.sv */
module usr_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic core_clk_i,        // Core clock
   input wire logic rst_b_i,           // Async reset, active low
   input wire logic [W-1:0] async_i,   // Asynchronous inputs
   output logic [W-1:0] level_o        // Filtered level
);
   import usr_pkg::*;

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] level;
   logic [W-1:0] next_level;

   // Only s2 and s3 are compared; s1 feeds s2 alone
   always_comb begin
      next_level = level;
      for (int i = 0; i < W; i++) begin
         if (s2[i] == s3[i]) begin
            next_level[i] = s3[i];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1 <= RST_VAL;
         s2 <= RST_VAL;
         s3 <= RST_VAL;
         level <= RST_VAL;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
         level <= next_level;
      end
   end

   assign level_o = level;

endmodule

/* hw/usr_fifo.sv */
module usr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic core_clk_i,      // Core clock
   input wire logic rst_b_i,         // Async reset, active low
   input wire logic flush_i,         // Drop all entries
   input wire logic in_valid_i,      // Write request
   output logic in_ready_o,          // Room for a word
   input wire logic [W-1:0] in_data_i, // Write data
   output logic out_valid_o,         // Head word present
   input wire logic out_ready_i,     // Head consumed
   output logic [W-1:0] out_data_o   // Head word
);
   import usr_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [CW-1:0] count;
   logic in_ready;
   logic [AW-1:0] next_wr_idx;
   logic [AW-1:0] next_rd_idx;
   logic [CW-1:0] next_count;
   logic next_in_ready;
   logic push;
   logic pop;

   always_comb begin
      push = in_valid_i && in_ready;
      pop = out_valid_o && out_ready_i;
      next_wr_idx = wr_idx;
      next_rd_idx = rd_idx;
      next_count = count;
      if (flush_i) begin
         next_wr_idx = '0;
         next_rd_idx = '0;
         next_count = '0;
      end else begin
         if (push) begin
            next_wr_idx = (wr_idx == LAST_IDX) ? '0 : AW'(wr_idx + 1'b1);
         end
         if (pop) begin
            next_rd_idx = (rd_idx == LAST_IDX) ? '0 : AW'(rd_idx + 1'b1);
         end
         if (push && !pop) begin
            next_count = CW'(count + 1'b1);
         end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
         end
      end
      next_in_ready = (next_count != FULL_CNT);
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end else begin
         wr_idx <= next_wr_idx;
         rd_idx <= next_rd_idx;
         count <= next_count;
         in_ready <= next_in_ready;
      end
   end

   // Storage has no reset; valid guards every read
   always_ff @(posedge core_clk_i) begin
      if (push && !flush_i) begin
         mem[wr_idx] <= in_data_i;
      end
   end

   assign in_ready_o = in_ready;
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_idx];

endmodule

/* hw/usr_top.sv */
// Functional notes
// RULE1 - Eight-bit state with shift, load, hold
// RULE2 - Two mode selects alone choose operation
// RULE3 - Low master clear resets stages asynchronously
// RULE4 - After clear all stages and ends low
// RULE5 - State changes only on shift clock rise
// RULE6 - Load captures each parallel pin value
// RULE7 - Right shift: serial right into stage 0
// RULE8 - Left shift: serial left into stage 7
// RULE9 - Enabled pins drive out stage contents
// RULE10 - Either enable high floats the pins
// RULE11 - Floating pins never stop internal operation
// RULE12 - Load mode floats pins regardless of enables
// RULE13 - Stage 0 and 7 always on serial outputs
// RULE14 - Host drives pins only during load mode
module usr_top #(
   parameter int WIDTH = usr_pkg::USR_WIDTH,
   parameter int FIFO_DEPTH = usr_pkg::USR_FIFO_DEPTH
) (
   input wire logic core_clk_i,                    // Core clock, 40 MHz
   input wire logic rst_b_i,                       // Async reset, active low
   input wire logic shift_clock_i,                 // Pin clock, rising edge acts
   input wire logic mode_sel_lo_i,                 // Mode select low bit
   input wire logic mode_sel_hi_i,                 // Mode select high bit
   input wire logic ser_in_right_i,                // Serial in for right shift
   input wire logic ser_in_left_i,                 // Serial in for left shift
   input wire logic out_en_n_a_i,                  // Pin enable A, active low
   input wire logic out_en_n_b_i,                  // Pin enable B, active low
   input wire logic master_clear_n_i,              // Master clear, active low
   input wire logic [usr_pkg::USR_WIDTH-1:0] par_i, // Parallel pins, input side
   output logic [usr_pkg::USR_WIDTH-1:0] par_o,    // Parallel pins, output side
   output logic par_oe_n_o,                        // Pin drive, low drives
   output logic ser_out_first_o,                   // Stage 0
   output logic ser_out_last_o,                    // Stage 7
   input wire logic apply_stall_i,                 // Hold off queued edges
   output logic cmd_room_o,                        // Queue can take an edge
   output logic lost_edge_o                        // Edge dropped on full queue
);
   import usr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin capture

   usr_pins_t pins_raw;
   usr_pins_t pins;

   always_comb begin
      pins_raw.shift_clock = shift_clock_i;
      pins_raw.mode_sel_hi = mode_sel_hi_i;
      pins_raw.mode_sel_lo = mode_sel_lo_i;
      pins_raw.ser_in_right = ser_in_right_i;
      pins_raw.ser_in_left = ser_in_left_i;
      pins_raw.out_en_n_a = out_en_n_a_i;
      pins_raw.out_en_n_b = out_en_n_b_i;
      pins_raw.master_clear_n = master_clear_n_i;
      pins_raw.par_in = par_i;
   end

   // All pins share one delay so data stays aligned with its clock edge
   usr_sync #(
      .W(USR_PINS_W),
      .RST_VAL(USR_PINS_RST)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .async_i(pins_raw),
      .level_o(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Edge detect and mode decode

   logic clk_seen;
   logic next_clk_seen;
   logic clk_rise;
   usr_mode_t pin_mode;

   always_comb begin
      case ({pins.mode_sel_hi, pins.mode_sel_lo}) // RULE2
         USR_SEL_LOAD: pin_mode = USR_MODE_LOAD;
         USR_SEL_RIGHT: pin_mode = USR_MODE_RIGHT;
         USR_SEL_LEFT: pin_mode = USR_MODE_LEFT;
         default: pin_mode = USR_MODE_HOLD;
      endcase
      next_clk_seen = pins.shift_clock;
      clk_rise = pins.shift_clock && !clk_seen; // RULE5
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         clk_seen <= 1'b0;
      end else begin
         clk_seen <= next_clk_seen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge queue

   usr_cmd_t cmd_in;
   usr_cmd_t cmd_head;
   logic cmd_push;
   logic cmd_ready;
   logic cmd_valid;
   logic apply;
   logic flush;

   always_comb begin
      cmd_in.mode = pin_mode;
      cmd_in.ser_in_right = pins.ser_in_right;
      cmd_in.ser_in_left = pins.ser_in_left;
      cmd_in.par_in = pins.par_in;
      // Hold edges change nothing, so they take no queue room
      cmd_push = clk_rise && (pin_mode != USR_MODE_HOLD) && pins.master_clear_n;
      // Stale edges must not land once a clear has been seen
      flush = !pins.master_clear_n;
      apply = cmd_valid && !apply_stall_i; // RULE11
   end

   usr_fifo #(
      .W(USR_CMD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .flush_i(flush),
      .in_valid_i(cmd_push),
      .in_ready_o(cmd_ready),
      .in_data_i(cmd_in),
      .out_valid_o(cmd_valid),
      .out_ready_i(!apply_stall_i),
      .out_data_o(cmd_head)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Storage stages

   logic [WIDTH-1:0] stage;
   logic [WIDTH-1:0] next_stage;
   logic stage_rst_b;

   // Clear pin acts directly, ahead of the synchroniser
   assign stage_rst_b = rst_b_i && master_clear_n_i; // RULE3

   generate
      for (genvar i = 0; i < WIDTH; i++) begin : g_stage
         logic from_low;
         logic from_high;
         assign from_low = (i == 0) ? cmd_head.ser_in_right : stage[(i == 0) ? 0 : i - 1];
         assign from_high = (i == WIDTH - 1) ? cmd_head.ser_in_left : stage[(i == WIDTH - 1) ? i : i + 1];
         always_comb begin
            next_stage[i] = stage[i];
            if (apply) begin
               case (cmd_head.mode)
                  USR_MODE_LOAD: next_stage[i] = cmd_head.par_in[i]; // RULE6
                  USR_MODE_RIGHT: next_stage[i] = from_low; // RULE7
                  USR_MODE_LEFT: next_stage[i] = from_high; // RULE8
                  default: next_stage[i] = stage[i];
               endcase
            end
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i or negedge stage_rst_b) begin
      if (!stage_rst_b) begin
         stage <= USR_STAGE_RST; // RULE4
      end else begin
         stage <= next_stage; // RULE1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drive and flags

   logic oe_n;
   logic next_oe_n;
   logic lost;
   logic next_lost;

   always_comb begin
      // Drive only with both enables low and not in load mode
      next_oe_n = pins.out_en_n_a || pins.out_en_n_b || (pin_mode == USR_MODE_LOAD); // RULE10 RULE12
      next_lost = lost;
      if (!pins.master_clear_n) begin
         next_lost = 1'b0;
      end
      // No drop is counted in the clearing cycle, so the flag stays low
      if (clk_rise && (pin_mode != USR_MODE_HOLD) && pins.master_clear_n && !cmd_ready) begin
         next_lost = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oe_n <= USR_OE_N_RST;
         lost <= 1'b0;
      end else begin
         oe_n <= next_oe_n;
         lost <= next_lost;
      end
   end

   assign par_o = stage; // RULE9
   assign par_oe_n_o = oe_n;
   assign ser_out_first_o = stage[0]; // RULE13
   assign ser_out_last_o = stage[WIDTH-1]; // RULE13
   assign cmd_room_o = cmd_ready;
   assign lost_edge_o = lost;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk_i);
   endclocking
   // Raw clear moves stages between edges, so most checks stand down
   default disable iff (!rst_b_i || !master_clear_n_i);

   sequence right_apply_s;
      apply && (cmd_head.mode == USR_MODE_RIGHT);
   endsequence

   sequence left_apply_s;
      apply && (cmd_head.mode == USR_MODE_LEFT);
   endsequence

   sequence pins_off_s;
      pins.out_en_n_a || pins.out_en_n_b;
   endsequence

   sequence load_apply_s;
      apply && (cmd_head.mode == USR_MODE_LOAD);
   endsequence

   // A non-hold edge seen with the clear released
   sequence pin_edge_s;
      clk_rise && pins.master_clear_n && (pin_mode != USR_MODE_HOLD);
   endsequence

   load_capture_a: assert property (load_apply_s |=> stage == $past(cmd_head.par_in)) // RULE6
      else $error("load did not capture parallel data");

   shift_right_a: assert property (right_apply_s |=> // RULE7
      stage == {$past(stage[WIDTH-2:0]), $past(cmd_head.ser_in_right)})
      else $error("right shift result wrong");

   shift_left_a: assert property (left_apply_s |=> // RULE8
      stage == {$past(cmd_head.ser_in_left), $past(stage[WIDTH-1:1])})
      else $error("left shift result wrong");

   no_edge_a: assert property (!apply |=> $stable(stage)) // RULE5
      else $error("state changed without a clock edge");

   float_oe_a: assert property (pins_off_s |=> par_oe_n_o) // RULE10
      else $error("pins driven with an enable high");

   float_load_a: assert property (pin_mode == USR_MODE_LOAD |=> par_oe_n_o) // RULE12
      else $error("pins driven in load mode");

   drive_on_a: assert property (!pins.out_en_n_a && !pins.out_en_n_b && pin_mode != USR_MODE_LOAD // RULE9
      |=> !par_oe_n_o && par_o == stage)
      else $error("pins not driven while enabled");

   off_runs_a: assert property (pins_off_s ##0 right_apply_s |=> stage[0] == $past(cmd_head.ser_in_right)) // RULE11
      else $error("shift stalled while pins floated");

   ser_last_a: assert property (right_apply_s |=> ser_out_last_o == $past(stage[WIDTH-2])) // RULE13
      else $error("last serial output wrong after shift");

   clear_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_b_i) // RULE3 RULE4
      !master_clear_n_i |-> (stage == USR_STAGE_RST) && !ser_out_first_o && !ser_out_last_o)
      else $error("stages not low under master clear");

   mode_sel_a: assert property (clk_rise && pins.master_clear_n && pin_mode == USR_MODE_HOLD // RULE2
      && !cmd_valid |=> $stable(stage))
      else $error("hold edge changed state");

   hold_skip_a: assert property (clk_rise && pin_mode == USR_MODE_HOLD |-> !cmd_push) // RULE2
      else $error("hold edge took queue room");

   rise_once_a: assert property (clk_rise |=> !clk_rise) // RULE5
      else $error("one pin edge counted twice");

   // Queue accepts every non-hold edge it has room for while the clear is released
   edge_queued_a: assert property (pin_edge_s ##0 cmd_ready |=> cmd_valid) // RULE5
      else $error("accepted edge not queued");

   lost_set_a: assert property (pin_edge_s ##0 !cmd_ready |=> lost_edge_o) // RULE1
      else $error("dropped edge not flagged");

   // Flag must survive until the filtered clear, not just one cycle
   lost_keep_a: assert property (lost_edge_o && pins.master_clear_n |=> lost_edge_o) // RULE1
      else $error("lost edge flag fell early");

   clear_flush_a: assert property (!pins.master_clear_n |=> !cmd_valid && !lost_edge_o) // RULE3
      else $error("queue or flag kept through clear");

   right_first_a: assert property (right_apply_s |=> ser_out_first_o == $past(cmd_head.ser_in_right)) // RULE13
      else $error("first serial output wrong after right shift");

   left_first_a: assert property (left_apply_s |=> ser_out_first_o == $past(stage[1])) // RULE13
      else $error("first serial output wrong after left shift");

   left_last_a: assert property (left_apply_s |=> ser_out_last_o == $past(cmd_head.ser_in_left)) // RULE13
      else $error("last serial output wrong after left shift");

endmodule

/* testbench/usr_host_model.sv */
module usr_host_model (
   input wire logic core_clk_i,                       // Core clock
   input wire logic mode_sel_lo_i,                    // Mode select low bit
   input wire logic mode_sel_hi_i,                    // Mode select high bit
   input wire logic [usr_pkg::USR_WIDTH-1:0] load_i,  // Word offered in load mode
   input wire logic [usr_pkg::USR_WIDTH-1:0] dev_i,   // Device pin output side
   input wire logic dev_oe_n_i,                       // Device drive, low drives
   output logic [usr_pkg::USR_WIDTH-1:0] pin_o        // Resolved pin level
);
   timeunit 1ns;
   timeprecision 1ps;
   import usr_pkg::*;

   logic [USR_WIDTH-1:0] last_level = 8'h00;
   logic host_drive;

   // Waits for the device to let go, so the pins never see two drivers
   assign host_drive = mode_sel_lo_i & mode_sel_hi_i & dev_oe_n_i;

   always @(posedge core_clk_i) begin
      last_level <= pin_o;
   end

   always_comb begin
      if (!dev_oe_n_i) begin
         pin_o = dev_i;
      end else if (host_drive) begin
         pin_o = load_i;
      end else begin
         // No pull on the pins: a released bus must not look like old data
         pin_o = ~last_level;
      end
   end
endmodule

/* testbench/universal_shift_register_8bit_test.sv */
module universal_shift_register_8bit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import usr_pkg::*;

   logic core_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic shift_clock = 1'b0;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b0;
   logic ser_r = 1'b0;
   logic ser_l = 1'b0;
   logic en_n_a = 1'b0;
   logic en_n_b = 1'b0;
   logic clr_n = 1'b1;
   logic stall = 1'b0;
   logic [USR_WIDTH-1:0] load_data = 8'h00;
   logic [USR_WIDTH-1:0] par_in;
   logic [USR_WIDTH-1:0] par_out;
   logic [USR_WIDTH-1:0] golden;
   logic [USR_WIDTH-1:0] held;
   logic oe_n;
   logic first;
   logic last_bit;
   logic room;
   logic lost;
   int mismatches = 0;
   int comparisons = 0;

   always #12.5 core_clk_i = ~core_clk_i;

   usr_top uut (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .shift_clock_i(shift_clock),
      .mode_sel_lo_i(sel_lo),
      .mode_sel_hi_i(sel_hi),
      .ser_in_right_i(ser_r),
      .ser_in_left_i(ser_l),
      .out_en_n_a_i(en_n_a),
      .out_en_n_b_i(en_n_b),
      .master_clear_n_i(clr_n),
      .par_i(par_in),
      .par_o(par_out),
      .par_oe_n_o(oe_n),
      .ser_out_first_o(first),
      .ser_out_last_o(last_bit),
      .apply_stall_i(stall),
      .cmd_room_o(room),
      .lost_edge_o(lost)
   );

   usr_host_model host (
      .core_clk_i(core_clk_i),
      .mode_sel_lo_i(sel_lo),
      .mode_sel_hi_i(sel_hi),
      .load_i(load_data),
      .dev_i(par_out),
      .dev_oe_n_i(oe_n),
      .pin_o(par_in)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Tasks

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, want, seen);
      end
   endtask

   task automatic check_state(input logic [7:0] want);
      check("par_o", par_out, want);
      check("ser_out_first", {7'h00, first}, {7'h00, want[0]});
      check("ser_out_last", {7'h00, last_bit}, {7'h00, want[7]});
   endtask

   task automatic wait_clk(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask

   // Pins settle well before the rise: the filter and host turnaround need time
   task automatic edge_op(input logic [1:0] sel, input logic sr, input logic sl, input logic [7:0] d);
      @(negedge core_clk_i);
      {sel_hi, sel_lo} = sel;
      ser_r = sr;
      ser_l = sl;
      load_data = d;
      wait_clk(12);
      shift_clock = 1'b1;
      wait_clk(8);
      shift_clock = 1'b0;
      wait_clk(8);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Sequence

   initial begin
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      rst_b_i = 1'b1;
      wait_clk(10);
      check_state(8'h00);
      check("par_oe_n_o", {7'h00, oe_n}, 8'h00);
      edge_op(USR_SEL_LOAD, 1'b1, 1'b1, 8'hA5);
      check("par_oe_n_o", {7'h00, oe_n}, 8'h01);
      golden = 8'hA5;
      check_state(golden);
      edge_op(USR_SEL_HOLD, 1'b1, 1'b1, 8'h00);
      check_state(golden);
      check("par_pins", par_in, golden);
      for (int i = 0; i < 8; i++) begin
         edge_op(USR_SEL_RIGHT, i[0], ~i[0], 8'h00);
         golden = {golden[6:0], i[0]};
         check_state(golden);
      end
      for (int i = 0; i < 8; i++) begin
         edge_op(USR_SEL_LEFT, ~i[1], i[1], 8'h00);
         golden = {i[1], golden[7:1]};
         check_state(golden);
      end
      for (int k = 1; k < 4; k++) begin
         {en_n_b, en_n_a} = k[1:0];
         edge_op(USR_SEL_RIGHT, 1'b1, 1'b0, 8'h00);
         golden = {golden[6:0], 1'b1};
         check_state(golden);
         check("par_oe_n_o", {7'h00, oe_n}, 8'h01);
      end
      {en_n_b, en_n_a} = 2'h0;
      ser_r = 1'b0;
      ser_l = 1'b1;
      wait_clk(12);
      check("par_oe_n_o", {7'h00, oe_n}, 8'h00);
      check_state(golden);
      clr_n = 1'b0;
      #1;
      check_state(8'h00);
      edge_op(USR_SEL_LOAD, 1'b0, 1'b0, 8'hFF);
      check_state(8'h00);
      clr_n = 1'b1;
      wait_clk(10);
      golden = 8'h3C;
      edge_op(USR_SEL_LOAD, 1'b0, 1'b0, golden);
      check_state(golden);
      // Pending edges pile up while applying is held off
      held = golden;
      stall = 1'b1;
      for (int i = 0; i < 17; i++) begin
         edge_op(USR_SEL_RIGHT, i[1], 1'b0, 8'h00);
         if (i < 16) begin
            golden = {golden[6:0], i[1]};
         end
         if (i == 15) begin
            check("cmd_room_o", {7'h00, room}, 8'h00);
            check("lost_edge_o", {7'h00, lost}, 8'h00);
         end
      end
      check("lost_edge_o", {7'h00, lost}, 8'h01);
      check_state(held);
      stall = 1'b0;
      wait_clk(40);
      check_state(golden);
      check("cmd_room_o", {7'h00, room}, 8'h01);
      clr_n = 1'b0;
      wait_clk(8);
      check("lost_edge_o", {7'h00, lost}, 8'h00);
      check_state(8'h00);
      clr_n = 1'b1;
      wait_clk(10);
      end_sim();
   end

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge core_clk_i);
      mismatches++;
      end_sim();
   end
endmodule
